// file: design/otaibt_client.sv
// Purpose: Download client that builds block requests and checks block responses.
// Assumes: Request and response payloads arrive as byte streams with an end marker.
// Notes: Image data from responses whose header checks out passes through a small FIFO, before the response is accepted.
//
// Summary of operation
// [RULE_01] Keep requesting until announced image fully downloaded.
// [RULE_02] Server announces total image length earlier.
// [RULE_03] Request frame control byte is 0x01.
// [RULE_04] Client picks request sequence number.
// [RULE_05] Request command identifier is 0x03.
// [RULE_06] Field control zero, no optional fields.
// [RULE_07] Request carries manufacturer, image type, version.
// [RULE_08] Request carries four-byte starting file position.
// [RULE_09] One-byte data limit ends request, offset sixteen.
// [RULE_10] Multi-byte fields go least significant byte first.
// [RULE_11] Response frame control byte is 0x19.
// [RULE_12] Response sequence number echoes the request.
// [RULE_13] Response command identifier is 0x05.
// [RULE_14] Status success carries fields; abort carries none.
// [RULE_15] Abort status ends the download.
// [RULE_16] Wait-for-data status is unsupported.
// [RULE_17] Response echoes version, manufacturer and image type.
// [RULE_18] Response echoes requested file position.
// [RULE_19] Response data length within requested limit.
// [RULE_20] Data bytes follow; count equals length byte.
// [RULE_21] Advance position; discard mismatching responses. Data of a response that fails after its header still reaches the image output.
`timescale 1ns/1ps
module otaibt_client #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Download control.
  input wire logic start,
  input wire otaibt_pkg::otaibt_image_type image_info,
  input wire logic [7:0] max_data_size,
  // Request stream to the server.
  output logic tx_valid,
  input wire logic tx_ready,
  output otaibt_pkg::otaibt_byte_type tx_byte,
  // Response stream from the server.
  input wire logic rx_valid,
  output logic rx_ready,
  input wire otaibt_pkg::otaibt_byte_type rx_byte,
  // Image data out.
  output logic img_valid,
  input wire logic img_ready,
  output logic [7:0] img_data,
  // Progress and status.
  output logic busy,
  output logic done,
  output logic aborted,
  output logic discard,
  output logic [31:0] file_pos
);

  ////////////////////////////////////////////////////////////////////////////////

  otaibt_pkg::otaibt_state_type state_q;
  otaibt_pkg::otaibt_image_type img_q;
  logic [7:0] seq_q;
  logic [31:0] pos_q;
  logic [7:0] limit_q;
  logic [8:0] tx_idx_q;
  logic tx_valid_q;
  otaibt_pkg::otaibt_byte_type tx_byte_q;
  logic [8:0] rx_idx_q;
  logic rx_ok_q;
  logic [7:0] status_q;
  logic [7:0] len_q;
  logic [7:0] cnt_q;
  logic discard_q;
  logic tx_fire;
  logic rx_fire;
  logic byte_ok;
  logic frame_ok;
  logic want_push;
  logic push;
  logic fifo_in_ready;
  logic end_abort;
  logic end_accept;
  logic end_reject;
  logic [31:0] next_pos;
  logic [7:0] rx_len;
  logic [7:0] next_limit;
  logic [7:0] req_first;

  // Byte of the outstanding request at a given payload offset.
  function automatic logic [7:0] req_byte(input otaibt_pkg::otaibt_image_type img,
                                          input logic [7:0] seq,
                                          input logic [31:0] pos,
                                          input logic [7:0] limit,
                                          input logic [8:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      otaibt_pkg::OFS_FC: b = otaibt_pkg::FC_REQ; // RULE_03
      otaibt_pkg::OFS_SEQ: b = seq; // RULE_04
      otaibt_pkg::OFS_CMD: b = otaibt_pkg::CMD_REQ; // RULE_05
      otaibt_pkg::OFS_CTRL: b = otaibt_pkg::FIELD_CTRL_NONE; // RULE_06
      otaibt_pkg::OFS_MFR: b = img.mfr_code[7:0]; // RULE_07 RULE_10
      otaibt_pkg::OFS_MFR + 9'h001: b = img.mfr_code[15:8];
      otaibt_pkg::OFS_TYPE: b = img.image_kind[7:0];
      otaibt_pkg::OFS_TYPE + 9'h001: b = img.image_kind[15:8];
      otaibt_pkg::OFS_VER: b = img.version[7:0];
      otaibt_pkg::OFS_VER + 9'h001: b = img.version[15:8];
      otaibt_pkg::OFS_VER + 9'h002: b = img.version[23:16];
      otaibt_pkg::OFS_VER + 9'h003: b = img.version[31:24];
      otaibt_pkg::OFS_POS: b = pos[7:0]; // RULE_08 RULE_10
      otaibt_pkg::OFS_POS + 9'h001: b = pos[15:8];
      otaibt_pkg::OFS_POS + 9'h002: b = pos[23:16];
      otaibt_pkg::OFS_POS + 9'h003: b = pos[31:24];
      otaibt_pkg::OFS_LIMIT: b = limit; // RULE_09
      default: b = 8'h00;
    endcase
    return b;
  endfunction : req_byte

  // Limit of the next request, never more than what remains of the image.
  function automatic logic [7:0] calc_limit(input logic [31:0] total,
                                            input logic [31:0] pos,
                                            input logic [7:0] max_sz);
    logic [31:0] remain;
    remain = total - pos;
    if (remain < {24'h000000, max_sz}) begin
      return remain[7:0];
    end
    return max_sz;
  endfunction : calc_limit

  ////////////////////////////////////////////////////////////////////////////////

  assign tx_fire = tx_valid_q && tx_ready;
  assign rx_fire = rx_valid && rx_ready;
  // Length of the response in flight, taken straight from the length byte while it passes.
  assign rx_len = (rx_idx_q == otaibt_pkg::OFS_DSIZE) ? rx_byte.data : len_q;
  assign next_pos = pos_q + {24'h000000, rx_len}; // RULE_21
  assign req_first = otaibt_pkg::FC_REQ;

  // Checks one response byte against the outstanding request.
  always_comb begin
    byte_ok = 1'b1;
    if (rx_idx_q == otaibt_pkg::OFS_FC) begin
      byte_ok = (rx_byte.data == otaibt_pkg::FC_RSP); // RULE_11
    end else if (rx_idx_q == otaibt_pkg::OFS_SEQ) begin
      byte_ok = (rx_byte.data == seq_q); // RULE_12
    end else if (rx_idx_q == otaibt_pkg::OFS_CMD) begin
      byte_ok = (rx_byte.data == otaibt_pkg::CMD_RSP); // RULE_13
    end else if (rx_idx_q == otaibt_pkg::OFS_CTRL) begin
      // Wait-for-data and any other code fail here.
      byte_ok = (rx_byte.data == otaibt_pkg::ST_SUCCESS) ||
                (rx_byte.data == otaibt_pkg::ST_ABORT); // RULE_14 RULE_16
    end else if (rx_idx_q < otaibt_pkg::OFS_DSIZE) begin
      byte_ok = (status_q == otaibt_pkg::ST_SUCCESS) &&
                (rx_byte.data == req_byte(img_q, seq_q, pos_q, limit_q, rx_idx_q)); // RULE_17 RULE_18
    end else if (rx_idx_q == otaibt_pkg::OFS_DSIZE) begin
      byte_ok = (rx_byte.data <= limit_q); // RULE_19
    end
  end

  assign frame_ok = rx_ok_q && byte_ok;

  // Data bytes are pushed only after a clean header and up to the length byte.
  assign want_push = rx_valid && rx_ok_q && (status_q == otaibt_pkg::ST_SUCCESS) &&
                     (rx_idx_q >= otaibt_pkg::OFS_DATA) && (cnt_q < len_q); // RULE_20
  assign push = want_push && fifo_in_ready;
  assign rx_ready = !(want_push && !fifo_in_ready);

  // Outcome of a response at its last byte.
  assign end_abort = rx_fire && rx_byte.last && frame_ok &&
                     (rx_idx_q >= otaibt_pkg::OFS_CTRL) &&
                     ((rx_idx_q == otaibt_pkg::OFS_CTRL) ? (rx_byte.data == otaibt_pkg::ST_ABORT)
                                                         : (status_q == otaibt_pkg::ST_ABORT));
  assign end_accept = rx_fire && rx_byte.last && frame_ok &&
                      (status_q == otaibt_pkg::ST_SUCCESS) &&
                      (rx_idx_q >= otaibt_pkg::OFS_DSIZE) &&
                      (rx_idx_q == otaibt_pkg::OFS_DSIZE + {1'b0, rx_len}); // RULE_20
  assign end_reject = rx_fire && rx_byte.last && !end_abort && !end_accept;
  assign next_limit = calc_limit(img_q.total_size, next_pos, max_data_size);

  ////////////////////////////////////////////////////////////////////////////////

  // Main sequence of the download.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= otaibt_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        otaibt_pkg::ST_IDLE, otaibt_pkg::ST_DONE, otaibt_pkg::ST_ABRT: begin
          if (start) begin
            state_q <= (image_info.total_size == otaibt_pkg::POS_RST) ?
                       otaibt_pkg::ST_DONE : otaibt_pkg::ST_SEND;
          end
        end
        otaibt_pkg::ST_SEND: begin
          if (tx_fire && tx_byte_q.last) begin
            state_q <= otaibt_pkg::ST_WAIT;
          end
        end
        otaibt_pkg::ST_WAIT: begin
          if (end_abort) begin
            state_q <= otaibt_pkg::ST_ABRT; // RULE_15
          end else if (end_accept) begin
            state_q <= (next_pos >= img_q.total_size) ?
                       otaibt_pkg::ST_DONE : otaibt_pkg::ST_SEND; // RULE_01 RULE_02
          end
        end
        default: state_q <= otaibt_pkg::ST_IDLE;
      endcase
    end
  end

  // Image identity, file position, sequence number and limit of the request.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      img_q <= '0;
      pos_q <= otaibt_pkg::POS_RST;
      seq_q <= otaibt_pkg::SEQ_RST;
      limit_q <= 8'h00;
    end else if (start && (state_q != otaibt_pkg::ST_SEND) && (state_q != otaibt_pkg::ST_WAIT)) begin
      img_q <= image_info;
      pos_q <= otaibt_pkg::POS_RST;
      seq_q <= seq_q + 8'h01; // RULE_04
      limit_q <= calc_limit(image_info.total_size, otaibt_pkg::POS_RST, max_data_size);
    end else if ((state_q == otaibt_pkg::ST_WAIT) && end_accept) begin
      pos_q <= next_pos; // RULE_21
      seq_q <= seq_q + 8'h01;
      limit_q <= next_limit;
    end
  end

  // Request output stage.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid_q <= 1'b0;
      tx_idx_q <= 9'h000;
      tx_byte_q <= '0;
    end else if ((state_q != otaibt_pkg::ST_SEND) && (state_q != otaibt_pkg::ST_WAIT) &&
                 start && (image_info.total_size != otaibt_pkg::POS_RST)) begin
      tx_valid_q <= 1'b1;
      tx_idx_q <= otaibt_pkg::OFS_FC;
      tx_byte_q <= '{data: req_first, last: 1'b0};
    end else if ((state_q == otaibt_pkg::ST_WAIT) && end_accept &&
                 (next_pos < img_q.total_size)) begin
      tx_valid_q <= 1'b1; // RULE_01
      tx_idx_q <= otaibt_pkg::OFS_FC;
      tx_byte_q <= '{data: req_first, last: 1'b0};
    end else if (tx_fire) begin
      if (tx_byte_q.last) begin
        tx_valid_q <= 1'b0;
      end else begin
        tx_idx_q <= tx_idx_q + 9'h001;
        tx_byte_q <= '{data: req_byte(img_q, seq_q, pos_q, limit_q, tx_idx_q + 9'h001),
                       last: (tx_idx_q + 9'h001 == otaibt_pkg::OFS_LIMIT)}; // RULE_09
      end
    end
  end

  // Response parser: byte index, running check, status and data length.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_idx_q <= 9'h000;
      rx_ok_q <= 1'b1;
      status_q <= otaibt_pkg::ST_SUCCESS;
      len_q <= 8'h00;
      cnt_q <= 8'h00;
    end else if (rx_fire) begin
      if (rx_byte.last) begin
        rx_idx_q <= 9'h000;
        rx_ok_q <= 1'b1;
        cnt_q <= 8'h00;
      end else begin
        if (rx_idx_q != 9'h1ff) begin
          rx_idx_q <= rx_idx_q + 9'h001;
        end
        rx_ok_q <= frame_ok && (state_q == otaibt_pkg::ST_WAIT); // RULE_21
        if (push) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
      if (rx_idx_q == otaibt_pkg::OFS_CTRL) begin
        status_q <= rx_byte.data;
      end
      if (rx_idx_q == otaibt_pkg::OFS_DSIZE) begin
        len_q <= rx_byte.data;
      end
    end
  end

  // One-cycle mark of a response that was thrown away.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= end_reject || (rx_fire && rx_byte.last && (state_q != otaibt_pkg::ST_WAIT)); // RULE_21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  otaibt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_data_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte.data),
    .out_valid(img_valid),
    .out_ready(img_ready),
    .out_data(img_data)
  );

  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
  assign busy = (state_q == otaibt_pkg::ST_SEND) || (state_q == otaibt_pkg::ST_WAIT);
  assign done = (state_q == otaibt_pkg::ST_DONE);
  assign aborted = (state_q == otaibt_pkg::ST_ABRT);
  assign discard = discard_q;
  assign file_pos = pos_q;

endmodule : otaibt_client

// file: design/otaibt_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active low reset.
// Notes: Full and empty come from pointers one bit wider than the address.
`timescale 1ns/1ps
module otaibt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;

  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_q <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
    end
  end

endmodule : otaibt_fifo

// file: design/otaibt_pkg.sv
// Purpose: Shared constants and types of the image block transfer client.
// Assumes: Payload bytes travel one per beat, least significant byte first.
// Notes: Offsets are byte positions inside a message payload.
package otaibt_pkg;

  // Header codes of the request and the response.
  localparam logic [7:0] FC_REQ = 8'h01;
  localparam logic [7:0] FC_RSP = 8'h19;
  localparam logic [7:0] CMD_REQ = 8'h03;
  localparam logic [7:0] CMD_RSP = 8'h05;
  localparam logic [7:0] FIELD_CTRL_NONE = 8'h00;
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_ABORT = 8'h95;
  localparam logic [7:0] ST_WAIT_DATA = 8'h97;

  // Payload offsets; those below OFS_LIMIT are shared by both messages, OFS_DATA is response only.
  localparam logic [8:0] OFS_FC = 9'h000;
  localparam logic [8:0] OFS_SEQ = 9'h001;
  localparam logic [8:0] OFS_CMD = 9'h002;
  localparam logic [8:0] OFS_CTRL = 9'h003;
  localparam logic [8:0] OFS_MFR = 9'h004;
  localparam logic [8:0] OFS_TYPE = 9'h006;
  localparam logic [8:0] OFS_VER = 9'h008;
  localparam logic [8:0] OFS_POS = 9'h00c;
  localparam logic [8:0] OFS_LIMIT = 9'h010;
  localparam logic [8:0] OFS_DSIZE = 9'h010;
  localparam logic [8:0] OFS_DATA = 9'h011;

  // Values after reset.
  localparam logic [7:0] SEQ_RST = 8'h00;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  // Image identity and announced total size.
  typedef struct packed {
    logic [15:0] mfr_code;
    logic [15:0] image_kind;
    logic [31:0] version;
    logic [31:0] total_size;
  } otaibt_image_type;

  // One payload byte on a stream, with the end of message marker.
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } otaibt_byte_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b010,
    ST_ABRT = 3'b110
  } otaibt_state_type;

endpackage : otaibt_pkg

// file: tb/otaibt_client_properties.sv
// Purpose: Checks the request stream and status outputs of the client.
// Assumes: Image info and data limit stay steady during a download.
// Notes: The byte index counts request bytes taken by the sink.
`timescale 1ns/1ps
module otaibt_client_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Control and request stream.
  input wire logic start,
  input wire otaibt_pkg::otaibt_image_type image_info,
  input wire logic [7:0] max_data_size,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire otaibt_pkg::otaibt_byte_type tx_byte,
  // Response and image streams.
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire otaibt_pkg::otaibt_byte_type rx_byte,
  input wire logic img_valid,
  input wire logic img_ready,
  input wire logic [7:0] img_data,
  // Status.
  input wire logic busy,
  input wire logic done,
  input wire logic aborted,
  input wire logic discard,
  input wire logic [31:0] file_pos
);
  logic [4:0] idx_q;
  logic [7:0] seq_q;
  logic [31:0] rem;
  logic [7:0] lim;
  assign rem = image_info.total_size - file_pos;
  assign lim = (rem < {24'h0, max_data_size}) ? rem[7:0] : max_data_size;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_q <= 5'h00;
    end else if (tx_valid && tx_ready) begin
      idx_q <= tx_byte.last ? 5'h00 : idx_q + 5'h01;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_q <= 8'h00;
    end else if (tx_valid && tx_ready && idx_q == 5'h01) begin
      seq_q <= tx_byte.data;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  fc_code_a: assert property ($rose(tx_valid) |-> tx_byte.data == 8'h01)
    else $error("request opens with a wrong code");
  hold_req_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("request byte changed before it was taken");
  cmd_code_a: assert property (tx_valid && idx_q == 5'h02 |-> tx_byte.data == 8'h03)
    else $error("request command byte is wrong");
  ctrl_zero_a: assert property (tx_valid && idx_q == 5'h03 |-> tx_byte.data == 8'h00)
    else $error("field control byte is not zero");
  last_mark_a: assert property (tx_valid |-> tx_byte.last == (idx_q == 5'h10))
    else $error("request end marker misplaced");
  mfr_order_a: assert property (tx_valid && idx_q == 5'h05 |->
    tx_byte.data == image_info.mfr_code[15:8])
    else $error("manufacturer high byte misplaced");
  pos_order_a: assert property (tx_valid && idx_q == 5'h0c |->
    tx_byte.data == file_pos[7:0])
    else $error("position low byte misplaced");
  limit_val_a: assert property (tx_valid && idx_q == 5'h10 |-> tx_byte.data == lim)
    else $error("request limit byte is wrong");
  seq_step_a: assert property (tx_valid && idx_q == 5'h01 |->
    tx_byte.data == seq_q + 8'h01)
    else $error("sequence number did not step by one");
  abort_halt_a: assert property (aborted |-> !busy && !tx_valid)
    else $error("client still active after abort");
  done_full_a: assert property (done |-> file_pos >= image_info.total_size)
    else $error("download reported done too early");
  disc_pulse_a: assert property (discard |=> !discard)
    else $error("discard longer than one cycle");
endmodule : otaibt_client_properties

bind otaibt_client otaibt_client_properties u_props (
  .core_clk(core_clk), .reset_n(reset_n), .start(start), .image_info(image_info),
  .max_data_size(max_data_size), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
  .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data), .busy(busy),
  .done(done), .aborted(aborted), .discard(discard), .file_pos(file_pos)
);

// file: tb/otaibt_client_tb.sv
// Purpose: Self-checking bench of the block transfer client.
// Assumes: Image byte at file position p has the value p modulo 256.
// Notes: Every scenario starts from a fresh reset.
`timescale 1ns/1ps
module otaibt_client_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  // Identity values are arbitrary.
  otaibt_pkg::otaibt_image_type info = {16'h5a3c, 16'h0002, 32'h0a0b0c0d, 32'h0};
  logic [7:0] max_sz = 8'h00;
  logic img_ready = 1'b0;
  logic tx_valid, tx_ready, rx_valid, rx_ready, img_valid, busy, done, aborted, discard;
  otaibt_pkg::otaibt_byte_type tx_byte, rx_byte;
  logic [7:0] img_data, req_n, seq;
  logic [7:0] seen = 8'h00;
  logic [7:0] req [0:16];
  logic [31:0] file_pos;
  logic [31:0] img_pos = 32'h0;
  logic [31:0] disc_n = 32'h0;
  logic [2:0] mode = 3'h0;
  logic slow = 1'b0, stall = 1'b0, img_chk = 1'b1, saw_full = 1'b0;
  int mismatches = 0, total_checks = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  otaibt_client u_dut (.core_clk(core_clk), .reset_n(reset_n), .start(start),
    .image_info(info), .max_data_size(max_sz), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
    .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data), .busy(busy),
    .done(done), .aborted(aborted), .discard(discard), .file_pos(file_pos));
  otaibt_server_model u_srv (.core_clk(core_clk), .reset_n(reset_n), .mode(mode),
    .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .req(req), .req_n(req_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    img_ready <= ~stall;
    cycles++;
    if (discard === 1'b1) disc_n++;
    if (rx_ready === 1'b0) saw_full = 1'b1;
    if (img_valid === 1'b1 && img_ready === 1'b1) begin
      if (img_chk) check(img_data, img_pos[7:0]);
      img_pos++;
    end
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  function automatic logic [7:0] exp_byte(input int i, input logic [7:0] s,
    input logic [31:0] p, input logic [7:0] l);
    logic [127:0] f;
    f = {p, info.version, info.image_kind, info.mfr_code, 8'h00, 8'h03, s, 8'h01};
    return (i == 16) ? l : f[8*i +: 8];
  endfunction : exp_byte
  ////////////////////////////////////////////////////////////////////////
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    img_pos = 32'h0;
    seq = 8'h00;
    seen = req_n;
  endtask : do_reset
  task automatic run(input logic [31:0] tot, input logic [7:0] mx);
    logic [31:0] p;
    logic [7:0] l;
    int k;
    p = 32'h0;
    info.total_size <= tot;
    max_sz <= mx;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    while (p < tot && aborted !== 1'b1) begin
      l = (tot - p < {24'h0, mx}) ? 8'(tot - p) : mx;
      k = 0;
      while (req_n == seen && aborted !== 1'b1 && k < 400) begin
        @(posedge core_clk);
        k++;
      end
      if (req_n != seen) begin
        seen = req_n;
        seq++;
        for (int i = 0; i < 17; i++) check(req[i], exp_byte(i, seq, p, l));
        p += l;
      end
    end
    k = 0;
    while ((done !== 1'b1 && aborted !== 1'b1 || img_valid === 1'b1) && k < 400) begin
      @(posedge core_clk);
      k++;
    end
  endtask : run
  task automatic test_full;
    do_reset();
    run(32'd40, 8'h10);
    check(done, 1'b1);
    check(file_pos, 32'd40);
    check(img_pos, 32'd40);
  endtask : test_full
  task automatic test_fill;
    do_reset();
    slow <= 1'b1;
    stall <= 1'b1;
    saw_full = 1'b0;
    fork
      run(32'd40, 8'h20);
      begin
        repeat (200) @(posedge core_clk);
        check(saw_full, 1'b1);
        stall <= 1'b0;
      end
    join
    check(img_pos, 32'd40);
    check(file_pos, 32'd40);
    slow <= 1'b0;
  endtask : test_fill
  task automatic test_abort;
    do_reset();
    mode <= 3'h1;
    run(32'd40, 8'h10);
    repeat (30) @(posedge core_clk);
    check(aborted, 1'b1);
    check(busy, 1'b0);
    check(file_pos, 32'h0);
    check(req_n, seen);
    do_reset();
    mode <= 3'h0;
    run(32'h0, 8'h10);
    check(done, 1'b1);
    check(req_n, seen);
  endtask : test_abort
  task automatic test_reject;
    logic [31:0] d0;
    for (int m = 2; m < 5; m++) begin
      do_reset();
      mode <= 3'(m);
      img_chk <= (m != 4);
      d0 = disc_n;
      run(32'd8, 8'h08);
      check(disc_n - d0, 32'h1);
      check(file_pos, 32'd8);
      check(done, 1'b1);
    end
  endtask : test_reject
  initial begin
    test_full();
    test_fill();
    test_abort();
    test_reject();
    results();
  end
endmodule : otaibt_client_tb

// file: tb/otaibt_server_model.sv
// Purpose: Upgrade server that answers each block request of the client.
// Assumes: Mode 0 good, 1 abort, 2 bad sequence, 3 wait status, 4 short data.
// Notes: Modes 2 to 4 send a faulty response and then a good one; data byte is position.
`timescale 1ns/1ps
module otaibt_server_model (
  // Clock, reset and behaviour.
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] mode,
  input wire logic slow,
  // Request stream.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire otaibt_pkg::otaibt_byte_type tx_byte,
  // Response stream.
  input wire logic rx_ready,
  output logic rx_valid,
  output otaibt_pkg::otaibt_byte_type rx_byte,
  // Last request and request count.
  output logic [7:0] req [0:16],
  output logic [7:0] req_n
);
  logic [7:0] rsp [0:272];
  int n;
  int cnt;
  task automatic put(input int len);
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= {rsp[i], i == len - 1};
      @(posedge core_clk);
      while (!rx_ready) @(posedge core_clk);
      if (slow || i == len - 1) begin
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        @(posedge core_clk);
      end
    end
  endtask : put
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte = '0;
    req_n = 8'h00;
    forever begin
      n = 0;
      while (n < 17) begin
        @(posedge core_clk);
        if (tx_valid && tx_ready) begin
          req[n] <= tx_byte.data;
          n++;
        end
        tx_ready <= (n < 17) && (!slow || !tx_ready);
      end
      req_n <= req_n + 8'h01;
      @(posedge core_clk);
      for (int v = (mode > 3'h1) ? 0 : 1; v < 2; v++) begin
        rsp[0] = 8'h19;
        rsp[1] = (v == 0 && mode == 3'h2) ? req[1] + 8'h01 : req[1];
        rsp[2] = 8'h05;
        rsp[3] = (mode == 3'h1) ? 8'h95 : (v == 0 && mode == 3'h3) ? 8'h97 : 8'h00;
        for (int k = 4; k < 17; k++) rsp[k] = req[k];
        cnt = (v == 0 && mode == 3'h4) ? req[16] - 1 : req[16];
        for (int k = 0; k < cnt; k++) rsp[17 + k] = req[12] + 8'(k);
        put((mode == 3'h1) ? 4 : 17 + cnt);
      end
    end
  end
endmodule : otaibt_server_model
